// File: spi_front_pkg.sv
// constants and types for the serial front end of the supervisor memory
//
// Behaviour
// - serial input is sampled on every rising serial clock edge while chip select is low, modes (0,0) and (1,1)
// - serial output changes only on falling serial clock edges, and only in the status and memory read phases
// - serial output is high impedance whenever chip select is high
// - chip select high means standby, except a running write cycle completes first
// - instruction, then address, then data all arrive through one input shifter
// - write-protect input high never blocks any write
// - write-protect low with protect-pin enable set rejects status register writes
// - first byte after chip select falls is decoded; unknown codes are ignored
// - opcodes 06, 04, 05, 01, 03, 02 for the six instructions
// - protect-pin enable is bit 7 of the status register
// - during a write cycle only the status read instruction is honoured
package spi_front_pkg;
  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_MEMORY_CMD = 8'h03;
  localparam logic [7:0] WRITE_MEMORY_CMD = 8'h02;
  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int PROTECT_PIN_ENABLE_BIT = 7;
  localparam int BLOCK_PROTECT_HI_BIT = 3;
  localparam int BLOCK_PROTECT_LO_BIT = 2;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h8C;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ----------------------------------------------------------------
  // timing and sizes
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLE_US = 5;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * CLK_MHZ;
  localparam int ADDR_BYTES = 2;
  localparam int MEM_ADDR_W = 5;
  localparam int MEM_DEPTH = 32;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_WSTAT, ST_RSTAT, ST_SKIP
  } phase_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pins_t;
  typedef struct packed {
    logic so;
    logic so_oe_n;
  } out_pins_t;
endpackage : spi_front_pkg

// File: spi_eeprom_serial_front_end.sv
// serial slave front end with status register, write latch and small page store
`timescale 1ns/10ps
module spi_eeprom_serial_front_end
  import spi_front_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial link pins from the host
  input wire pins_t pins_in,
  // serial output pin, enable low while driven
  output out_pins_t pins_out,
  // state seen by the rest of the chip
  output logic [7:0] status_out,
  output logic standby_out
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  pins_t meta_ff, sync_ff, prev_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
      sync_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
      prev_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges found on the synchronised copies only; host owns the clock
  logic sck_rise, sck_fall, cs_fall, cs_rise, sel;
  assign sck_rise = sync_ff.sck & ~prev_ff.sck;
  assign sck_fall = ~sync_ff.sck & prev_ff.sck;
  assign cs_fall = ~sync_ff.cs_n & prev_ff.cs_n;
  assign cs_rise = sync_ff.cs_n & ~prev_ff.cs_n;
  assign sel = ~sync_ff.cs_n & ~prev_ff.cs_n;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  phase_t phase_ff, nxt_phase;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] shin_ff, nxt_shin;
  logic [7:0] shout_ff, nxt_shout;
  logic [0:0] abyte_ff, nxt_abyte;
  logic [MEM_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] mem_ff [MEM_DEPTH], nxt_mem [MEM_DEPTH];
  logic pend_ff, nxt_pend;
  logic [9:0] busy_cnt_ff, nxt_busy_cnt;
  logic so_ff, nxt_so;
  logic so_oe_n_ff, nxt_so_oe_n;
  logic [7:0] byte_in;
  logic is_write_ff, nxt_is_write;

  // status write allowed only when latch set and pin protection inactive
  function automatic logic status_writable(input logic [7:0] st, input logic wp_n);
    status_writable = st[WRITE_LATCH_BIT]
      & (wp_n | ~st[PROTECT_PIN_ENABLE_BIT]);
  endfunction : status_writable

  assign byte_in = {shin_ff[6:0], sync_ff.si};

  // next-state logic for the serial path except the write-memory flag
  always_comb begin
    nxt_phase = phase_ff;
    nxt_bit = bit_ff;
    nxt_shin = shin_ff;
    nxt_shout = shout_ff;
    nxt_abyte = abyte_ff;
    nxt_addr = addr_ff;
    nxt_status = status_ff;
    nxt_mem = mem_ff;
    nxt_pend = pend_ff;
    nxt_busy_cnt = busy_cnt_ff;
    nxt_so = so_ff;
    nxt_so_oe_n = so_oe_n_ff;
    // internal write cycle runs regardless of chip select
    if (status_ff[BUSY_BIT]) begin
      if (busy_cnt_ff == 10'(WRITE_CYCLE_CYC - 1)) begin
        nxt_status[BUSY_BIT] = 1'b0;
        nxt_status[WRITE_LATCH_BIT] = 1'b0; // back to write disable
        nxt_busy_cnt = '0;
      end else begin
        nxt_busy_cnt = busy_cnt_ff + 10'h001;
      end
    end
    if (cs_fall) begin
      nxt_phase = ST_CMD;
      nxt_bit = '0;
      nxt_abyte = '0;
      nxt_so_oe_n = 1'b0;
    end else if (cs_rise) begin
      // a completed page load starts programming only at the rising select
      if (pend_ff && !status_ff[BUSY_BIT]) begin
        nxt_status[BUSY_BIT] = 1'b1;
      end
      nxt_pend = 1'b0;
      nxt_phase = ST_IDLE;
      nxt_so_oe_n = 1'b1;
    end else if (sel && sck_rise) begin
      nxt_shin = byte_in;
      nxt_bit = bit_ff + 3'h1;
      if (bit_ff == BIT_LAST) begin
        case (phase_ff)
          ST_CMD: begin
            nxt_phase = ST_SKIP;
            // busy device only answers the status read
            if (status_ff[BUSY_BIT] && byte_in != READ_STATUS_CMD) begin
              nxt_phase = ST_SKIP;
            end else begin
              case (byte_in)
                SET_WRITE_LATCH_CMD: nxt_status[WRITE_LATCH_BIT] = 1'b1;
                CLEAR_WRITE_LATCH_CMD: nxt_status[WRITE_LATCH_BIT] = 1'b0;
                READ_STATUS_CMD: begin
                  nxt_phase = ST_RSTAT;
                  nxt_shout = status_ff;
                end
                WRITE_STATUS_CMD: nxt_phase = ST_WSTAT;
                READ_MEMORY_CMD, WRITE_MEMORY_CMD: begin
                  nxt_phase = ST_ADDR;
                  nxt_pend = 1'b0;
                end
                default: nxt_phase = ST_SKIP;
              endcase
            end
          end
          ST_ADDR: begin
            nxt_abyte = abyte_ff + 1'b1;
            if (abyte_ff == 1'(ADDR_BYTES - 1)) begin
              nxt_addr = byte_in[MEM_ADDR_W-1:0];
              // opcode flag picks the data phase; latch is checked per data byte
              nxt_phase = is_write_ff ? ST_WDATA : ST_RDATA;
              nxt_shout = mem_ff[byte_in[MEM_ADDR_W-1:0]];
            end
          end
          ST_WDATA: begin
            // page roll-over: low address bits wrap within the store
            if (status_ff[WRITE_LATCH_BIT]) begin
              nxt_mem[addr_ff] = byte_in;
              nxt_pend = 1'b1;
            end
            nxt_addr = addr_ff + 5'h01;
          end
          ST_RDATA: begin
            nxt_addr = addr_ff + 5'h01;
            nxt_shout = mem_ff[addr_ff + 5'h01];
          end
          ST_RSTAT: nxt_shout = status_ff;
          ST_WSTAT: begin
            if (status_writable(status_ff, sync_ff.wp_n)) begin
              nxt_status = (status_ff & ~STATUS_WRITE_MASK) | (byte_in & STATUS_WRITE_MASK);
              nxt_status[WRITE_LATCH_BIT] = 1'b0;
            end
            nxt_phase = ST_SKIP;
          end
          default: nxt_phase = phase_ff;
        endcase
      end
    end else if (sel && sck_fall && (phase_ff == ST_RDATA || phase_ff == ST_RSTAT)) begin
      nxt_so = shout_ff[7];
      nxt_shout = {shout_ff[6:0], 1'b0};
    end
  end

  // write-memory flag taken from the opcode byte, read in the address phase
  always_comb begin
    nxt_is_write = is_write_ff;
    if (sel && sck_rise && bit_ff == BIT_LAST && phase_ff == ST_CMD) begin
      nxt_is_write = (byte_in == WRITE_MEMORY_CMD);
    end
  end

  // registers of the serial path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= ST_IDLE;
      bit_ff <= '0;
      shin_ff <= '0;
      shout_ff <= '0;
      abyte_ff <= '0;
      addr_ff <= '0;
      status_ff <= STATUS_RESET;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      pend_ff <= 1'b0;
      busy_cnt_ff <= '0;
      so_ff <= 1'b0;
      so_oe_n_ff <= 1'b1;
      is_write_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      bit_ff <= nxt_bit;
      shin_ff <= nxt_shin;
      shout_ff <= nxt_shout;
      abyte_ff <= nxt_abyte;
      addr_ff <= nxt_addr;
      status_ff <= nxt_status;
      mem_ff <= nxt_mem;
      pend_ff <= nxt_pend;
      busy_cnt_ff <= nxt_busy_cnt;
      so_ff <= nxt_so;
      so_oe_n_ff <= nxt_so_oe_n;
      is_write_ff <= nxt_is_write;
    end
  end

  // outputs straight from flip-flops
  logic standby_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      standby_ff <= 1'b1;
    end else begin
      standby_ff <= sync_ff.cs_n & ~nxt_status[BUSY_BIT];
    end
  end
  assign pins_out = '{so: so_ff, so_oe_n: so_oe_n_ff};
  assign status_out = status_ff;
  assign standby_out = standby_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hiz_when_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_ff.cs_n && prev_ff.cs_n |-> so_oe_n_ff)
    else $error("serial output driven while deselected");
  so_on_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(so_ff) |-> $past(sck_fall))
    else $error("serial output changed off a falling edge");
  bit_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cs_fall |=> bit_ff == 3'h0 && phase_ff == ST_CMD)
    else $error("bit counter not cleared on select");
  abandon_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cs_rise |=> phase_ff == ST_IDLE)
    else $error("transaction not abandoned");
  wp_block_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    phase_ff == ST_WSTAT && !sync_ff.wp_n && status_ff[PROTECT_PIN_ENABLE_BIT]
    |=> $stable(status_ff[PROTECT_PIN_ENABLE_BIT]))
    else $error("status written under pin protection");
  latch_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel && sck_rise && bit_ff == BIT_LAST && phase_ff == ST_CMD
    && byte_in == SET_WRITE_LATCH_CMD && !status_ff[BUSY_BIT]
    |=> status_ff[WRITE_LATCH_BIT])
    else $error("write latch not set");
  busy_ignore_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    status_ff[BUSY_BIT] && phase_ff == ST_CMD && sck_rise && sel && bit_ff == BIT_LAST
    && byte_in != READ_STATUS_CMD |=> phase_ff == ST_SKIP)
    else $error("instruction honoured while busy");
  sample_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel && sck_rise && phase_ff == ST_CMD && bit_ff != BIT_LAST
    |=> shin_ff[0] == $past(sync_ff.si))
    else $error("input not sampled on rising edge");
  busy_ends_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(status_ff[BUSY_BIT]) |-> ##[1:600] !status_ff[BUSY_BIT])
    else $error("write cycle did not finish");
  cov_status_read_c: cover property (@(posedge ref_clk) phase_ff == ST_RSTAT && sck_fall);
  cov_write_cycle_c: cover property (@(posedge ref_clk) $rose(status_ff[BUSY_BIT]));
  cov_wp_block_c: cover property (@(posedge ref_clk)
    phase_ff == ST_WSTAT && !sync_ff.wp_n && status_ff[PROTECT_PIN_ENABLE_BIT]);
endmodule : spi_eeprom_serial_front_end

// File: spi_host_model.sv
// host side bus master model that drives the serial link of the front end
`timescale 1ns/10ps
module spi_host_model
  import spi_front_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // device output pins
  input wire out_pins_t dev_out,
  // link pins toward the device
  output pins_t pins
);
  // idle level of the serial clock, high in mode (1,1)
  logic mode_hi = 1'b0;
  initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  // clock parks at its idle level before select falls
  task start();
    @(posedge ref_clk) pins.sck <= mode_hi;
    repeat (4) @(posedge ref_clk);
    pins.cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : start
  // released input flips so no stale bit can pass for data
  task stop();
    @(posedge ref_clk) pins.sck <= mode_hi;
    repeat (4) @(posedge ref_clk);
    pins.cs_n <= 1'b1;
    pins.si <= ~pins.si;
    repeat (8) @(posedge ref_clk);
  endtask : stop
  // n bits msb first, 80 ns per bit; so taken in the high phase
  task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge ref_clk) pins.sck <= 1'b0;
      pins.si <= tx[i];
      repeat (4) @(posedge ref_clk);
      pins.sck <= 1'b1;
      repeat (2) @(posedge ref_clk);
      // an undriven line reads inverted, so a missing enable cannot pass
      rx[i] = dev_out.so_oe_n ? ~dev_out.so : dev_out.so;
      repeat (1) @(posedge ref_clk);
    end
  endtask : xfer
  task set_wp(input logic v);
    @(posedge ref_clk) pins.wp_n <= v;
  endtask : set_wp
endmodule : spi_host_model

// File: tb_top.sv
// self-checking bench for the serial front end
`timescale 1ns/10ps
module tb_top;
  import spi_front_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  pins_t pins;
  out_pins_t pins_out;
  logic [7:0] status_out;
  logic standby_out;
  logic [7:0] rx;
  int err_count = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  spi_eeprom_serial_front_end i_spi_eeprom_serial_front_end (.ref_clk(ref_clk), .nrst(nrst),
    .pins_in(pins), .pins_out(pins_out), .status_out(status_out), .standby_out(standby_out));
  spi_host_model i_spi_host_model (.ref_clk(ref_clk), .dev_out(pins_out), .pins(pins));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one framed session of n whole bytes, first byte in the top bits; rx keeps the last
  task send(input logic [39:0] b, input int n);
    i_spi_host_model.start();
    for (int k = 0; k < n; k++) begin
      i_spi_host_model.xfer(b[39-8*k -: 8], 8, rx);
    end
    i_spi_host_model.stop();
  endtask : send
  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    check("status", status_out, 8'h00);
    check("standby", {7'h00, standby_out}, 8'h01);
    check("oe_n", {7'h00, pins_out.so_oe_n}, 8'h01);
    $display("test reset done");
  endtask : t_reset
  // latch set and clear, unknown code, select rising inside a status write byte
  task t_latch();
    send(40'h06_0000_0000, 1);
    check("latch set", status_out, 8'h02);
    send(40'hA5_0000_0000, 1);
    check("unknown op", status_out, 8'h02);
    send(40'h04_0000_0000, 1);
    check("latch clr", status_out, 8'h00);
    send(40'h06_0000_0000, 1);
    // a cut data byte must not reach the status register
    i_spi_host_model.start();
    i_spi_host_model.xfer(8'h01, 8, rx);
    i_spi_host_model.xfer(8'hFF, 5, rx);
    i_spi_host_model.stop();
    check("partial", status_out, 8'h02);
    $display("test latch done");
  endtask : t_latch
  // status writes under the protect pin, read back over so
  task t_status();
    send(40'h06_0000_0000, 1);
    send(40'h01_FF00_0000, 2);
    check("write_status_cmd pin high", status_out, 8'h8C);
    i_spi_host_model.start();
    check("oe_n sel", {7'h00, pins_out.so_oe_n}, 8'h00);
    check("standby sel", {7'h00, standby_out}, 8'h00);
    i_spi_host_model.xfer(8'h05, 8, rx);
    i_spi_host_model.xfer(8'h00, 8, rx);
    i_spi_host_model.stop();
    check("read_status_cmd", rx, 8'h8C);
    check("oe_n desel", {7'h00, pins_out.so_oe_n}, 8'h01);
    i_spi_host_model.set_wp(1'b0);
    send(40'h06_0000_0000, 1);
    send(40'h01_0000_0000, 2);
    check("write_status_cmd blocked", status_out, 8'h8E);
    i_spi_host_model.set_wp(1'b1);
    send(40'h01_0000_0000, 2);
    check("write_status_cmd free", status_out, 8'h00);
    $display("test status done");
  endtask : t_status
  // page write, busy window, ignored write, read back in mode (1,1)
  task t_memory();
    send(40'h06_0000_0000, 1);
    send(40'h02_0000_A53C, 5);
    check("busy", {7'h00, status_out[BUSY_BIT]}, 8'h01);
    check("standby busy", {7'h00, standby_out}, 8'h00);
    send(40'h02_0001_7700, 4);
    send(40'h05_0000_0000, 2);
    check("read_status_cmd busy", {7'h00, rx[BUSY_BIT]}, 8'h01);
    repeat (WRITE_CYCLE_CYC + 100) @(posedge ref_clk);
    check("idle", status_out, 8'h00);
    check("standby idle", {7'h00, standby_out}, 8'h01);
    i_spi_host_model.mode_hi = 1'b1;
    send(40'h03_0000_0000, 4);
    check("read 0", rx, 8'hA5);
    send(40'h03_0000_0000, 5);
    check("read 1", rx, 8'h3C);
    $display("test memory done");
  endtask : t_memory
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_latch();
    t_status();
    t_memory();
    test_done();
  end
  // run needs about 3300 cycles; this limit leaves ample margin
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    test_done();
  end
endmodule : tb_top
